// >>> rtl/gptu_pkg.sv
package gptu_pkg;

   // clock and count resolution
   localparam int CLK_PERIOD_NS = 8;
   localparam int COARSE_RES_NS = 400;
   localparam int FINE_RES_NS   = 200;
   localparam int COARSE_CYC    = COARSE_RES_NS / CLK_PERIOD_NS;
   localparam int FINE_CYC      = FINE_RES_NS / CLK_PERIOD_NS;
   localparam int CBASE_W       = $clog2(COARSE_CYC);
   localparam int FBASE_W       = $clog2(FINE_CYC);
   localparam int DIV_W         = 8;
   localparam int TIMER_W       = 16;
   localparam int NTIM          = 5;

   // timer slots
   localparam int TIM_AUXA  = 0;
   localparam int TIM_CORE  = 1;
   localparam int TIM_AUXB  = 2;
   localparam int TIM_FAUX  = 3;
   localparam int TIM_FCORE = 4;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_CNT    = 8'h20;
   localparam logic [7:0] OFS_FINE_CAPTURE_RELOAD_REG = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h44;
   localparam logic [5:0] IDX_CTRL   = OFS_CTRL[7:2];
   localparam logic [5:0] IDX_CNT    = OFS_CNT[7:2];
   localparam logic [5:0] IDX_FINE_CAPTURE_RELOAD_REG = OFS_FINE_CAPTURE_RELOAD_REG[7:2];
   localparam logic [5:0] IDX_STATUS = OFS_STATUS[7:2];

   // control word fields
   localparam int F_RUN   = 0;
   localparam int F_DIR   = 1;
   localparam int F_MODE  = 2;
   localparam int F_PRE   = 4;
   localparam int F_EDGE  = 7;
   localparam int F_GPOL  = 9;
   localparam int F_XDIR  = 10;
   localparam int F_TOUT  = 11;
   localparam int F_TSRC  = 12;
   localparam int F_CAPSEL = 13;
   localparam int F_TGLTR = 14;
   localparam int F_CLR   = 15;

   // mode field codes
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] MODE_GATED = 2'h1;
   localparam logic [1:0] MODE_COUNT = 2'h2;
   localparam logic [1:0] MODE_AUX   = 2'h3;

   // reset values
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [15:0] FINE_CAPTURE_RELOAD_REG_RST = 16'h0000;
   localparam logic [9:0]  FLAGS_RST  = 10'h000;
   localparam logic [15:0] CNT_RST    = 16'h0000;

   // bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic       HRESP_OKAY = 1'h0;

endpackage

// >>> rtl/gptu_timer.sv
`timescale 1ns/1ps

module gptu_timer #(
   parameter int W = gptu_pkg::TIMER_W
) (
   input  logic         hclk,
   input  logic         hresetn,
   input  logic         step,
   input  logic         up,
   input  logic         load,
   input  logic [W-1:0] load_val,
   output logic [W-1:0] count,
   output logic         wrap
);

   typedef struct packed {
      logic [W-1:0] count;
   } gptu_timer_state_t;

   gptu_timer_state_t s;
   gptu_timer_state_t next_s;

   // load wins over a step in the same cycle
   always_comb begin
      next_s = s;
      if (load) begin
         next_s.count = load_val;
      end else if (step) begin
         next_s.count = up ? s.count + 1'b1 : s.count - 1'b1;
      end
   end

   // wrap ignores load so a reload may ride on the wrap itself
   assign wrap  = step & (up ? (&s.count) : ~(|s.count));
   assign count = s.count;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule // gptu_timer

// >>> rtl/gptu_top.sv
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// - five 16-bit timers, coarse three, fine two
// - chaining only inside its own module
// - coarse timers: timer, gated or counter mode
// - timer mode counts prescaled system clock
// - counter mode counts edges on its pin
// - gated mode counts while gate pin active
// - one pin per coarse timer, gate or clock
// - coarse finest period 400 ns
// - software up/down per timer
// - core direction also driven by pin
// - core toggle latch flips on every wrap
// - core toggle to pin or aux clock
// - aux in capture/reload mode stops counting
// - aux captures core on pin edge
// - aux reloads core on pin or toggle
// - two aux reloads alternate, giving free PWM
// - fine finest period 200 ns
// - fine timers prescaled, independent up/down
// - fine toggle latch clocks aux or pin
// - fine core wrap clocks timebases, reloads
// - capture register takes fine aux on edge
// - optional clear of fine aux on capture
module gptu_top #(
   parameter int TW = gptu_pkg::TIMER_W
) (
   input  logic        hclk,
   input  logic        hresetn,
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   input  logic        hready,
   output logic [31:0] hrdata,
   output logic        hreadyout,
   output logic        hresp,
   input  logic [2:0]  coarse_pin,
   input  logic        coarse_dir_pin,
   input  logic        fine_capture_pin,
   output logic        coarse_toggle_pin,
   output logic        fine_toggle_pin,
   output logic        compare_timebase_clk
);

   typedef struct packed {
      logic [2:0][15:0]              ctrl_c;
      logic [1:0][15:0]              ctrl_f;
      logic [TW-1:0]                 fine_capture_reload_reg;
      logic [9:0]                    flags;
      logic [2:0]                    cp_s1;
      logic [2:0]                    cp_s2;
      logic [2:0]                    cp_s3;
      logic                          dir_s1;
      logic                          dir_s2;
      logic                          fc_s1;
      logic                          fc_s2;
      logic                          fc_s3;
      logic [gptu_pkg::CBASE_W-1:0]  cbase;
      logic [gptu_pkg::FBASE_W-1:0]  fbase;
      logic [gptu_pkg::DIV_W-1:0]    cdiv;
      logic [gptu_pkg::DIV_W-1:0]    fdiv;
      logic                          ctgl;
      logic                          ftgl;
      logic                          ctgl_pin;
      logic                          ftgl_pin;
      logic                          cmp_clk;
      logic                          dphase;
      logic                          dwrite;
      logic [5:0]                    daddr;
   } gptu_state_t;

   gptu_state_t                      s;
   gptu_state_t                      next_s;
   logic [gptu_pkg::NTIM-1:0][15:0]  ctrl;
   logic [gptu_pkg::NTIM-1:0]        step;
   logic [gptu_pkg::NTIM-1:0]        up;
   logic [gptu_pkg::NTIM-1:0]        ld;
   logic [gptu_pkg::NTIM-1:0]        hw_ld;
   logic [gptu_pkg::NTIM-1:0]        bus_ld;
   logic [gptu_pkg::NTIM-1:0]        wrap;
   logic [gptu_pkg::NTIM-1:0][TW-1:0] cnt;
   logic [gptu_pkg::NTIM-1:0][TW-1:0] lval;
   logic [gptu_pkg::NTIM-1:0][TW-1:0] hw_lval;
   logic [2:0]                       pin_rise;
   logic [2:0]                       pin_fall;
   logic [2:0]                       cpre;
   logic [1:0]                       aux_step;
   logic [1:0]                       aux_cap;
   logic [1:0]                       aux_rel;
   logic                             ctick;
   logic                             ftick;
   logic                             ctgl_rise;
   logic                             ctgl_fall;
   logic                             ftgl_rise;
   logic                             ftgl_fall;
   logic                             core_step;
   logic                             core_load;
   logic [TW-1:0]                    core_lval;
   logic                             faux_step;
   logic                             fcore_step;
   logic                             fcap;
   logic                             faux_clr;
   logic                             fcore_rel;
   logic                             bus_wr;
   logic [9:0]                       ovf;
   logic [9:0]                       flag_clr;
   logic [31:0]                      rd;

   // divide-by-2^pre on top of the base tick
   function automatic logic pre_ok(input logic [gptu_pkg::DIV_W-1:0] div,
                                   input logic [2:0] pre);
      logic [gptu_pkg::DIV_W-1:0] m;
      m = ~({gptu_pkg::DIV_W{1'b1}} << pre);
      return (div & m) == m;
   endfunction

   function automatic logic edge_hit(input logic rise, input logic fall,
                                     input logic [1:0] sel);
      return (sel[0] & rise) | (sel[1] & fall);
   endfunction

   function automatic logic mode_step(input logic [15:0] c, input logic pre,
                                      input logic lvl, input logic trg);
      logic st;
      st = 1'b0;
      unique case (c[gptu_pkg::F_MODE+:2])
         gptu_pkg::MODE_TIMER: st = pre;
         gptu_pkg::MODE_GATED: st = pre & (lvl == c[gptu_pkg::F_GPOL]);
         gptu_pkg::MODE_COUNT: st = trg;
         gptu_pkg::MODE_AUX:   st = 1'b0;
      endcase
      return c[gptu_pkg::F_RUN] & st;
   endfunction

   assign ctrl = {s.ctrl_f, s.ctrl_c};

   // base ticks: every 50 cycles = 400 ns, every 25 = 200 ns
   assign ctick = (s.cbase == gptu_pkg::CBASE_W'(gptu_pkg::COARSE_CYC - 1));
   assign ftick = (s.fbase == gptu_pkg::FBASE_W'(gptu_pkg::FINE_CYC - 1));

   // only the third stage and second stage feed edge logic
   assign pin_rise = s.cp_s2 & ~s.cp_s3;
   assign pin_fall = ~s.cp_s2 & s.cp_s3;

   assign ctgl_rise = wrap[gptu_pkg::TIM_CORE] & ~s.ctgl;
   assign ctgl_fall = wrap[gptu_pkg::TIM_CORE] & s.ctgl;
   assign ftgl_rise = wrap[gptu_pkg::TIM_FCORE] & ~s.ftgl;
   assign ftgl_fall = wrap[gptu_pkg::TIM_FCORE] & s.ftgl;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         cpre[i] = ctick & pre_ok(s.cdiv, s.ctrl_c[i][gptu_pkg::F_PRE+:3]);
      end
   end

   // core counts its own pin only; the toggle source does not apply to it
   assign core_step = mode_step(s.ctrl_c[gptu_pkg::TIM_CORE], cpre[gptu_pkg::TIM_CORE],
                                s.cp_s2[gptu_pkg::TIM_CORE],
                                edge_hit(pin_rise[gptu_pkg::TIM_CORE],
                                         pin_fall[gptu_pkg::TIM_CORE],
                                         s.ctrl_c[gptu_pkg::TIM_CORE][gptu_pkg::F_EDGE+:2]));

   always_comb begin
      logic [15:0] c;
      logic        ev;
      logic        tev;
      logic        spec;
      int          i;
      c   = '0;
      ev  = 1'b0;
      tev = 1'b0;
      spec = 1'b0;
      i   = 0;
      for (int k = 0; k < 2; k++) begin
         i    = (k == 0) ? gptu_pkg::TIM_AUXA : gptu_pkg::TIM_AUXB;
         c    = s.ctrl_c[i];
         ev   = edge_hit(pin_rise[i], pin_fall[i], c[gptu_pkg::F_EDGE+:2]);
         tev  = edge_hit(ctgl_rise, ctgl_fall, c[gptu_pkg::F_EDGE+:2]);
         // gated pin level, counter pin edge or core toggle edge
         aux_step[k] = mode_step(c, cpre[i], s.cp_s2[i],
                                 c[gptu_pkg::F_TSRC] ? tev : ev);
         spec        = (c[gptu_pkg::F_MODE+:2] == gptu_pkg::MODE_AUX);
         aux_cap[k]  = spec & c[gptu_pkg::F_CAPSEL] & ev;
         aux_rel[k]  = spec & ~c[gptu_pkg::F_CAPSEL]
                       & (c[gptu_pkg::F_TGLTR] ? tev : ev);
      end
   end

   // rising toggle picks aux a, falling picks aux b: alternate high/low
   assign core_load = |aux_rel;
   assign core_lval = aux_rel[0] ? cnt[gptu_pkg::TIM_AUXA] : cnt[gptu_pkg::TIM_AUXB];

   // fine module: prescaled clock or own core toggle, never coarse signals
   assign fcore_step = ctrl[gptu_pkg::TIM_FCORE][gptu_pkg::F_RUN] & ftick
                       & pre_ok(s.fdiv, ctrl[gptu_pkg::TIM_FCORE][gptu_pkg::F_PRE+:3]);
   assign faux_step  = ctrl[gptu_pkg::TIM_FAUX][gptu_pkg::F_RUN]
                       & (ctrl[gptu_pkg::TIM_FAUX][gptu_pkg::F_TSRC]
                          ? edge_hit(ftgl_rise, ftgl_fall,
                                     ctrl[gptu_pkg::TIM_FAUX][gptu_pkg::F_EDGE+:2])
                          : ftick & pre_ok(s.fdiv,
                                           ctrl[gptu_pkg::TIM_FAUX][gptu_pkg::F_PRE+:3]));
   assign fcap       = ctrl[gptu_pkg::TIM_FCORE][gptu_pkg::F_CAPSEL]
                       & edge_hit(s.fc_s2 & ~s.fc_s3, ~s.fc_s2 & s.fc_s3,
                                  ctrl[gptu_pkg::TIM_FCORE][gptu_pkg::F_EDGE+:2]);
   assign faux_clr   = fcap & ctrl[gptu_pkg::TIM_FCORE][gptu_pkg::F_CLR];
   assign fcore_rel  = wrap[gptu_pkg::TIM_FCORE] & ctrl[gptu_pkg::TIM_FCORE][gptu_pkg::F_TGLTR];

   assign step = {fcore_step, faux_step, aux_step[1], core_step, aux_step[0]};
   assign hw_ld = {fcore_rel, faux_clr, aux_cap[1], core_load, aux_cap[0]};
   assign hw_lval = {s.fine_capture_reload_reg, gptu_pkg::CNT_RST, cnt[gptu_pkg::TIM_CORE],
                     core_lval, cnt[gptu_pkg::TIM_CORE]};

   assign bus_wr = s.dphase & s.dwrite;

   genvar g;
   generate
      for (g = 0; g < gptu_pkg::NTIM; g++) begin : g_tim
         // core direction pin xors the software direction
         if (g == gptu_pkg::TIM_CORE) begin : g_dir
            assign up[g] = ~(ctrl[g][gptu_pkg::F_DIR]
                             ^ (ctrl[g][gptu_pkg::F_XDIR] & s.dir_s2));
         end else begin : g_dir
            assign up[g] = ~ctrl[g][gptu_pkg::F_DIR];
         end
         // software write of the count beats a hardware load
         assign bus_ld[g] = bus_wr & (s.daddr == gptu_pkg::IDX_CNT + 6'(g));
         assign ld[g]     = bus_ld[g] | hw_ld[g];
         assign lval[g]   = bus_ld[g] ? hwdata[TW-1:0] : hw_lval[g];
         gptu_timer #(
            .W        (TW)
         ) u_tim (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .step     (step[g]),
            .up       (up[g]),
            .load     (ld[g]),
            .load_val (lval[g]),
            .count    (cnt[g]),
            .wrap     (wrap[g])
         );
      end
   endgenerate

   assign ovf = {wrap & ~up, wrap & up};
   assign flag_clr = (bus_wr && s.daddr == gptu_pkg::IDX_STATUS) ? hwdata[9:0] : 10'h000;

   always_comb begin
      next_s = s;
      next_s.cp_s1  = coarse_pin;
      next_s.cp_s2  = s.cp_s1;
      next_s.cp_s3  = s.cp_s2;
      next_s.dir_s1 = coarse_dir_pin;
      next_s.dir_s2 = s.dir_s1;
      next_s.fc_s1  = fine_capture_pin;
      next_s.fc_s2  = s.fc_s1;
      next_s.fc_s3  = s.fc_s2;

      next_s.cbase = ctick ? '0 : s.cbase + 1'b1;
      next_s.fbase = ftick ? '0 : s.fbase + 1'b1;
      if (ctick) begin
         next_s.cdiv = s.cdiv + 1'b1;
      end
      if (ftick) begin
         next_s.fdiv = s.fdiv + 1'b1;
      end

      if (wrap[gptu_pkg::TIM_CORE]) begin
         next_s.ctgl = ~s.ctgl;
      end
      if (wrap[gptu_pkg::TIM_FCORE]) begin
         next_s.ftgl = ~s.ftgl;
      end
      next_s.ctgl_pin = next_s.ctgl & s.ctrl_c[gptu_pkg::TIM_CORE][gptu_pkg::F_TOUT];
      next_s.ftgl_pin = next_s.ftgl & s.ctrl_f[1][gptu_pkg::F_TOUT];
      next_s.cmp_clk  = wrap[gptu_pkg::TIM_FCORE];

      // set beats a same-cycle write-one clear
      next_s.flags = (s.flags & ~flag_clr) | ovf;

      for (int i = 0; i < 3; i++) begin
         if (bus_wr && s.daddr == gptu_pkg::IDX_CTRL + 6'(i)) begin
            next_s.ctrl_c[i] = hwdata[15:0];
         end
      end
      for (int i = 0; i < 2; i++) begin
         if (bus_wr && s.daddr == gptu_pkg::IDX_CTRL + 6'(i + 3)) begin
            next_s.ctrl_f[i] = hwdata[15:0];
         end
      end
      if (bus_wr && s.daddr == gptu_pkg::IDX_FINE_CAPTURE_RELOAD_REG) begin
         next_s.fine_capture_reload_reg = hwdata[TW-1:0];
      end
      // a capture is never lost to a software write
      if (fcap) begin
         next_s.fine_capture_reload_reg = cnt[gptu_pkg::TIM_FAUX];
      end

      // zero-wait slave: address phase always taken when hready
      next_s.dphase = hsel & hready & htrans[1];
      next_s.dwrite = hwrite & (hsize == gptu_pkg::HSIZE_WORD);
      next_s.daddr  = haddr[7:2];
   end

   // read mux uses registered address, so a read right after a write sees it
   always_comb begin
      rd = 32'h0000_0000;
      for (int i = 0; i < gptu_pkg::NTIM; i++) begin
         if (s.daddr == gptu_pkg::IDX_CTRL + 6'(i)) begin
            rd = {16'h0000, ctrl[i]};
         end
         if (s.daddr == gptu_pkg::IDX_CNT + 6'(i)) begin
            rd = {{(32 - TW){1'b0}}, cnt[i]};
         end
      end
      if (s.daddr == gptu_pkg::IDX_FINE_CAPTURE_RELOAD_REG) begin
         rd = {{(32 - TW){1'b0}}, s.fine_capture_reload_reg};
      end
      if (s.daddr == gptu_pkg::IDX_STATUS) begin
         rd = {22'h000000, s.flags};
      end
   end

   assign hrdata               = rd;
   assign hreadyout            = 1'b1;
   assign hresp                = gptu_pkg::HRESP_OKAY;
   assign coarse_toggle_pin    = s.ctgl_pin;
   assign fine_toggle_pin      = s.ftgl_pin;
   assign compare_timebase_clk = s.cmp_clk;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s        <= '0;
         s.ctrl_c <= {3{gptu_pkg::CTRL_RST}};
         s.ctrl_f <= {2{gptu_pkg::CTRL_RST}};
         s.fine_capture_reload_reg <= gptu_pkg::FINE_CAPTURE_RELOAD_REG_RST;
         s.flags  <= gptu_pkg::FLAGS_RST;
      end else begin
         s <= next_s;
      end
   end

endmodule // gptu_top

// >>> testbench/gptu_properties.sv
`timescale 1ns/1ps

module gptu_properties #(
   parameter int TW = 16
) (
   input logic        hclk,
   input logic        hresetn,
   input logic        hsel,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic        hready,
   input logic [31:0] hrdata,
   input logic        hreadyout,
   input logic        hresp,
   input logic        coarse_toggle_pin,
   input logic        fine_toggle_pin,
   input logic        compare_timebase_clk
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic [4:0] gap;
   logic       unmapped;

   // saturates so the first pulse after reset is never judged
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) gap <= 5'h1f;
      else if (compare_timebase_clk) gap <= 5'h00;
      else if (gap != 5'h1f) gap <= gap + 5'h01;
   end

   assign unmapped = !(haddr[7:2] < 6'h05 || (haddr[7:2] >= 6'h08 && haddr[7:2] <= 6'h0c)
                       || haddr[7:2] == 6'h10 || haddr[7:2] == 6'h11);

   sequence s_rd;
      hsel && hready && htrans[1] && !hwrite;
   endsequence

   property p_ready; hreadyout; endproperty
   property p_okay; hresp == gptu_pkg::HRESP_OKAY; endproperty
   property p_upper; s_rd |=> hrdata[31:TW] == '0; endproperty
   property p_unmapped; s_rd ##0 unmapped |=> hrdata == 32'h0; endproperty
   property p_status;
      s_rd ##0 (haddr[7:2] == gptu_pkg::IDX_STATUS) |=> hrdata[31:10] == 22'h0;
   endproperty
   property p_pulse; compare_timebase_clk |=> !compare_timebase_clk; endproperty
   property p_spacing; compare_timebase_clk |-> gap >= 5'h18; endproperty
   property p_rst;
      $rose(hresetn) |-> !coarse_toggle_pin && !fine_toggle_pin && !compare_timebase_clk;
   endproperty

   a_ready: assert property (p_ready) else $error("hreadyout dropped");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_upper: assert property (p_upper) else $error("upper read bits set");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_status: assert property (p_status) else $error("status upper bits set");
   a_pulse: assert property (p_pulse) else $error("timebase pulse too long");
   a_spacing: assert property (p_spacing) else $error("timebase pulses too close");
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
endmodule // gptu_properties

bind gptu_top gptu_properties #(.TW(TW)) u_prop (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .coarse_toggle_pin(coarse_toggle_pin),
   .fine_toggle_pin(fine_toggle_pin), .compare_timebase_clk(compare_timebase_clk)
);

// >>> testbench/gptu_pin_model.sv
`timescale 1ns/1ps

module gptu_pin_model (
   input  logic       hclk,
   output logic [2:0] coarse_pin,
   output logic       coarse_dir_pin,
   output logic       fine_capture_pin
);
   // lines 0..2 coarse pins, 3 capture, 4 direction
   logic [4:0] lvl = 5'h00;

   assign coarse_pin       = lvl[2:0];
   assign fine_capture_pin = lvl[3];
   assign coarse_dir_pin   = lvl[4];

   // w cycles per level; short w stresses the two sync flops
   task automatic pulse(input int i, input int n, input int w);
      repeat (n) begin
         lvl[i] <= 1'b1;
         repeat (w) @(posedge hclk);
         lvl[i] <= 1'b0;
         repeat (w) @(posedge hclk);
      end
   endtask

   task automatic level(input int i, input logic v);
      lvl[i] <= v;
      @(posedge hclk);
   endtask
endmodule // gptu_pin_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   localparam int C = gptu_pkg::COARSE_CYC;
   localparam int F = gptu_pkg::FINE_CYC;
   localparam logic [31:0] A_CAP = 32'(gptu_pkg::OFS_FINE_CAPTURE_RELOAD_REG);
   localparam logic [31:0] A_ST  = 32'(gptu_pkg::OFS_STATUS);
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize, coarse_pin;
   logic        coarse_dir_pin, fine_capture_pin, coarse_toggle_pin;
   logic        fine_toggle_pin, compare_timebase_clk;
   int          errors = 0;
   int          checked = 0;
   int          n;

   gptu_top uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .coarse_pin(coarse_pin),
      .coarse_dir_pin(coarse_dir_pin), .fine_capture_pin(fine_capture_pin),
      .coarse_toggle_pin(coarse_toggle_pin), .fine_toggle_pin(fine_toggle_pin),
      .compare_timebase_clk(compare_timebase_clk)
   );

   gptu_pin_model pins (
      .hclk(hclk), .coarse_pin(coarse_pin), .coarse_dir_pin(coarse_dir_pin),
      .fine_capture_pin(fine_capture_pin)
   );

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   function automatic logic [31:0] ctl(input int i);
      return 32'(gptu_pkg::OFS_CTRL) + 32'(4 * i);
   endfunction

   function automatic logic [31:0] cnt(input int i);
      return 32'(gptu_pkg::OFS_CNT) + 32'(4 * i);
   endfunction

   task automatic tick(input int k);
      repeat (k) @(posedge hclk);
   endtask

   // entered just after a rising edge; read data lands in q
   task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] s,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= s;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, gptu_pkg::HSIZE_WORD, d);
   endtask

   task automatic rngv(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                       input logic [31:0] v);
      checked++;
      if ((v >= lo && v <= hi) !== 1'b1) begin
         errors++;
         $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, v);
      end
   endtask

   task automatic rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      bus(a, 1'b0, gptu_pkg::HSIZE_WORD, 32'h0);
      rngv($sformatf("reg %h", a), lo, hi, q);
   endtask

   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      rng(a, e, e);
   endtask

   task automatic pin(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic conclude();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // tests take about 6350 cycles
   initial begin
      tick(40000);
      errors++;
      $display("MISMATCH watchdog expected finish seen timeout");
      conclude();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      tick(10);
      hresetn <= 1'b1;
      tick(1);
      for (int i = 0; i < 5; i++) begin
         chk(ctl(i), 32'h0);
         chk(cnt(i), 32'h0);
      end
      chk(A_ST, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr(ctl(i), 32'hffff1230 + 32'(i));
         chk(ctl(i), 32'h1230 + 32'(i));
      end
      bus(ctl(0), 1'b1, 3'h0, 32'h0);
      chk(ctl(0), 32'h1230);
      wr(32'h18, 32'hffff);
      chk(32'h18, 32'h0);
      for (int i = 0; i < 5; i++) wr(ctl(i), 32'h0);
      $display("test registers done");
      for (int p = 0; p < 3; p++) begin
         wr(ctl(1), 32'h0);
         wr(cnt(1), 32'h0);
         wr(ctl(1), 32'h1 | 32'(p << 4));
         tick((10 << p) * C);
         rng(cnt(1), 32'h9, 32'hb);
      end
      $display("test prescaler done");
      wr(ctl(1), 32'h0);
      wr(cnt(1), 32'hffff);
      wr(A_ST, 32'h3ff);
      wr(ctl(1), 32'h0801);
      tick(2 * C);
      chk(A_ST, 32'h002);
      pin("coarse toggle", 1'b1, coarse_toggle_pin);
      wr(ctl(1), 32'h0);
      wr(cnt(1), 32'h0);
      wr(A_ST, 32'h3ff);
      wr(ctl(1), 32'h0803);
      // one base period: at least one step, at most two before the count read
      tick(C);
      chk(A_ST, 32'h040);
      pin("coarse toggle", 1'b0, coarse_toggle_pin);
      rng(cnt(1), 32'hfffe, 32'hffff);
      wr(ctl(1), 32'h0);
      wr(A_ST, 32'h040);
      chk(A_ST, 32'h0);
      $display("test wrap done");
      wr(cnt(1), 32'h64);
      pins.level(4, 1'b1);
      wr(ctl(1), 32'h0401);
      tick(10 * C);
      rng(cnt(1), 32'h59, 32'h5b);
      pins.level(4, 1'b0);
      wr(ctl(1), 32'h000c);
      $display("test direction done");
      wr(ctl(0), 32'h0089);
      pins.pulse(0, 5, 2);
      tick(4);
      chk(cnt(0), 32'h5);
      wr(ctl(2), 32'h0205);
      tick(5 * C);
      chk(cnt(2), 32'h0);
      pins.level(2, 1'b1);
      tick(10 * C);
      pins.level(2, 1'b0);
      rng(cnt(2), 32'h9, 32'hb);
      $display("test pin modes done");
      wr(cnt(1), 32'h1234);
      wr(cnt(0), 32'h0);
      wr(ctl(0), 32'h208d);
      pins.pulse(0, 1, 4);
      tick(2 * C);
      chk(cnt(0), 32'h1234);
      wr(cnt(2), 32'h0abc);
      wr(ctl(2), 32'h008d);
      pins.pulse(2, 1, 4);
      chk(cnt(1), 32'h0abc);
      // high two ticks, low three: period of 250 cycles, 200 high in two periods
      wr(cnt(0), 32'hfffe);
      wr(cnt(2), 32'hfffd);
      wr(ctl(0), 32'h408c);
      wr(ctl(2), 32'h410c);
      wr(cnt(1), 32'hffff);
      wr(ctl(1), 32'h0801);
      tick(6 * C);
      n = 0;
      repeat (10 * C) begin
         @(posedge hclk);
         if (coarse_toggle_pin === 1'b1) n++;
      end
      rngv("pwm high cycles", 32'hc8, 32'hc8, 32'(n));
      wr(ctl(1), 32'h0);
      $display("test capture reload done");
      wr(cnt(3), 32'h0077);
      wr(ctl(4), 32'ha080);
      pins.pulse(3, 1, 4);
      chk(A_CAP, 32'h0077);
      chk(cnt(3), 32'h0);
      wr(ctl(4), 32'h0);
      wr(cnt(4), 32'hffff);
      wr(A_ST, 32'h3ff);
      wr(ctl(4), 32'h0801);
      tick(2 * F);
      pin("fine toggle", 1'b1, fine_toggle_pin);
      chk(A_ST, 32'h010);
      wr(A_CAP, 32'hffff);
      wr(ctl(4), 32'h4801);
      // reload only bites at a wrap, so start from all ones
      wr(cnt(4), 32'hffff);
      n = 0;
      repeat (10 * F) begin
         @(posedge hclk);
         if (compare_timebase_clk === 1'b1) n++;
      end
      rngv("timebase pulses", 32'h9, 32'hb, 32'(n));
      $display("test fine module done");
      conclude();
   end
endmodule // tb_top
